// >>> src/dtm_tlb_regs.sv
// How it works
// - tag word writes only fill a staging register, arrays untouched
// - committing page entry writes staged tag and entry at round-robin slot
// - each of two pipes has its own array and staging registers
// - alternate mode field: 00 kernel, 01 executive, 10 supervisor, 11 user
// - flush-nonglobal write drops every entry whose global bit is clear
// - flush-all write drops every entry and resets allocation pointer
// - flush-single drops entries with matching page and matching process id
// - flush-single also drops global entries with matching page
// - translation miss or fault captures details into fault status
// - miss of a virtual page entry load leaves fault status alone
// - status bit 10 marks tag parity fault on initial probe
// - status bits 9:4 hold opcode; hardware load 3, store 7
// - status bit 3 marks write fault from fault-on-write flag
// - status bit 2 marks read fault from fault-on-read flag
// - status bit 1 marks access violation, bad address included
// - status bit 0 set for write transactions, clear for reads
// - memory unit control cleared at reset, superpages disabled
// - enable 2: va 47:46 equal 2 maps 43:13 directly
// - enable 1: va 47:41 equal 7E maps 40:13, sign extended
// - enable 0: va 47:30 equal 3FFFE maps 29:13, upper zero
// - superpage reference outside kernel mode is an access violation
//
// The placing of the registers and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "dtm_cfg.svh"

module dtm_tlb_regs import dtm_pkg::*; #(
    parameter int ENTRIES = 16,
    parameter int IDX_W = $clog2(ENTRIES)
) (
    input wire logic MCLK_I, // core clock
    input wire logic RST_I, // sync reset, active high
    input wire logic HSEL_I, // slave select
    input wire logic [31:0] HADDR_I, // byte address
    input wire logic [1:0] HTRANS_I, // transfer type
    input wire logic HWRITE_I, // write transfer
    input wire logic [2:0] HSIZE_I, // transfer size
    input wire logic HREADY_I, // bus ready
    input wire logic [31:0] HWDATA_I, // write data
    output logic HREADYOUT_O, // slave ready
    output logic HRESP_O, // response, always okay
    output logic [31:0] HRDATA_O, // read data
    input wire logic LKP_VALID_I, // translation request
    input wire logic LKP_PIPE_I, // memory pipe of request
    input wire logic [63:0] LKP_VA_I, // virtual address
    input wire logic LKP_WRITE_I, // store access
    input wire logic [5:0] LKP_OPCODE_I, // instruction opcode
    input wire logic LKP_HWMEM_I, // privileged hardware access
    input wire logic LKP_VPTE_I, // virtual page entry load
    input wire logic LKP_PERR_I, // tag probe parity error
    input wire logic [1:0] LKP_MODE_I, // current processor mode
    output logic LKP_DONE_O, // answer pulse
    output logic LKP_MISS_O, // translation miss
    output logic LKP_FAULT_O, // translation fault
    output logic [43:0] LKP_PA_O // physical address
);
    localparam int NPIPE = 2;

    // bus phase registers
    logic hsel_q;
    logic hwr_q;
    logic [7:0] haddr_q;
    logic wphase;
    logic a_go;

    // global control and status
    logic [1:0] alt_mode;
    logic [2:0] superpage_enables;
    logic [10:0] mem_mgmt_fault_status;
    logic flush_all_entries;
    logic flush_nonglobal_entries;

    // per-pipe staging
    logic [31:0] tag_lo [NPIPE];
    logic [31:0] tag_hi [NPIPE];
    logic [31:0] ent_lo [NPIPE];
    logic [31:0] fls_lo [NPIPE];
    dtm_asn_type process_id [NPIPE];
    logic [IDX_W-1:0] rr_ptr [NPIPE];
    logic lk_hit [NPIPE];
    dtm_pte_type lk_pte [NPIPE];

    // lookup stage registers
    logic lk_v;
    logic lk_pipe;
    logic [63:0] lk_va;
    logic lk_wr;
    logic [5:0] lk_opc;
    logic lk_hw;
    logic lk_vpte;
    logic lk_perr;
    logic [1:0] lk_mode;

    // offset compare used throughout the decode
    function automatic logic at_ofs(input logic [7:0] a, input logic [7:0] o);
        return a == o;
    endfunction

    assign a_go = HSEL_I && HTRANS_I[1] && HREADY_I;
    assign wphase = hsel_q && hwr_q;
    assign flush_all_entries = wphase && at_ofs(haddr_q, `DTM_OFS_FLUSH_ALL);
    assign flush_nonglobal_entries = wphase && at_ofs(haddr_q, `DTM_OFS_FLUSH_NG);

    // address phase capture
    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            hsel_q <= 1'b0;
            hwr_q <= 1'b0;
            haddr_q <= 8'h00;
        end else begin
            hsel_q <= a_go;
            hwr_q <= HWRITE_I;
            haddr_q <= HADDR_I[7:0];
        end
    end

    // zero wait state, okay only
    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            HREADYOUT_O <= 1'b1;
            HRESP_O <= 1'b0;
        end else begin
            HREADYOUT_O <= 1'b1;
            HRESP_O <= 1'b0;
        end
    end

    // read data, only fault status is readable
    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            HRDATA_O <= 32'h0000_0000;
        end else if (a_go && !HWRITE_I) begin
            if (at_ofs(HADDR_I[7:0], `DTM_OFS_FSTAT)) begin
                HRDATA_O <= {21'h00_0000, mem_mgmt_fault_status};
            end else begin
                HRDATA_O <= 32'h0000_0000;
            end
        end
    end

    // alternate mode register
    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            alt_mode <= `DTM_ALT_RST;
        end else if (wphase && at_ofs(haddr_q, `DTM_OFS_ALTMODE)) begin
            alt_mode <= HWDATA_I[1:0];
        end
    end

    // memory unit control
    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            superpage_enables <= `DTM_MCTL_RST;
        end else if (wphase && at_ofs(haddr_q, `DTM_OFS_MCTL)) begin
            superpage_enables <= HWDATA_I[`DTM_MCTL_SP_LSB +: 3];
        end
    end

    genvar p;
    generate
        for (p = 0; p < NPIPE; p++) begin : g_pipe
            logic [7:0] base;
            logic ent_go;
            logic fls_go;
            assign base = 8'(p * `DTM_PIPE_STRIDE);
            assign ent_go = wphase && at_ofs(haddr_q, base + `DTM_OFS_ENT_HI);
            assign fls_go = wphase && at_ofs(haddr_q, base + `DTM_OFS_FLS_HI);

            // staging words, no array change
            always_ff @(posedge MCLK_I) begin
                if (RST_I) begin
                    tag_lo[p] <= 32'h0000_0000;
                    tag_hi[p] <= 32'h0000_0000;
                    ent_lo[p] <= 32'h0000_0000;
                    fls_lo[p] <= 32'h0000_0000;
                end else if (wphase) begin
                    if (at_ofs(haddr_q, base + `DTM_OFS_TAG_LO)) begin
                        tag_lo[p] <= HWDATA_I;
                    end
                    if (at_ofs(haddr_q, base + `DTM_OFS_TAG_HI)) begin
                        tag_hi[p] <= HWDATA_I;
                    end
                    if (at_ofs(haddr_q, base + `DTM_OFS_ENT_LO)) begin
                        ent_lo[p] <= HWDATA_I;
                    end
                    if (at_ofs(haddr_q, base + `DTM_OFS_FLS_LO)) begin
                        fls_lo[p] <= HWDATA_I;
                    end
                end
            end

            // process id of the running process
            always_ff @(posedge MCLK_I) begin
                if (RST_I) begin
                    process_id[p] <= 8'h00;
                end else if (wphase && at_ofs(haddr_q, base + `DTM_OFS_PID)) begin
                    process_id[p] <= HWDATA_I[`DTM_PID_LSB +: 8];
                end
            end

            // round-robin allocation pointer
            always_ff @(posedge MCLK_I) begin
                if (RST_I || flush_all_entries) begin
                    rr_ptr[p] <= '0;
                end else if (ent_go) begin
                    rr_ptr[p] <= (rr_ptr[p] == IDX_W'(ENTRIES - 1)) ? '0 : rr_ptr[p] + 1'b1;
                end
            end

            // one array per memory pipe
            dtm_xlate_array #(
                .ENTRIES(ENTRIES),
                .IDX_W(IDX_W)
            ) u_array (
                .clk_i(MCLK_I),
                .rst_i(RST_I),
                .wr_en_i(ent_go),
                .wr_idx_i(rr_ptr[p]),
                .wr_vpn_i({tag_hi[p][15:0], tag_lo[p][31:13]}),
                .wr_asn_i(process_id[p]),
                .wr_pte_i({HWDATA_I, ent_lo[p]}),
                .inv_all_i(flush_all_entries),
                .inv_ng_i(flush_nonglobal_entries),
                .inv_one_i(fls_go),
                .inv_vpn_i({HWDATA_I[15:0], fls_lo[p][31:13]}),
                .inv_asn_i(process_id[p]),
                .lk_en_i(LKP_VALID_I && LKP_PIPE_I == 1'(p)),
                .lk_vpn_i(LKP_VA_I[47:13]),
                .lk_asn_i(process_id[p]),
                .lk_hit_o(lk_hit[p]),
                .lk_pte_o(lk_pte[p])
            );
        end
    endgenerate

    // lookup request capture
    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            lk_v <= 1'b0;
            lk_pipe <= 1'b0;
            lk_va <= 64'h0000_0000_0000_0000;
            lk_wr <= 1'b0;
            lk_opc <= 6'h00;
            lk_hw <= 1'b0;
            lk_vpte <= 1'b0;
            lk_perr <= 1'b0;
            lk_mode <= 2'h0;
        end else begin
            lk_v <= LKP_VALID_I;
            if (LKP_VALID_I) begin
                lk_pipe <= LKP_PIPE_I;
                lk_va <= LKP_VA_I;
                lk_wr <= LKP_WRITE_I;
                lk_opc <= LKP_OPCODE_I;
                lk_hw <= LKP_HWMEM_I;
                lk_vpte <= LKP_VPTE_I;
                lk_perr <= LKP_PERR_I;
                lk_mode <= LKP_HWMEM_I ? alt_mode : LKP_MODE_I;
            end
        end
    end

    // translation and fault evaluation
    logic hit;
    dtm_pte_type pte;
    logic va_bad;
    logic sp2;
    logic sp1;
    logic sp0;
    logic sp;
    logic perm;
    logic viol;
    logic for_f;
    logic wrflt;
    logic miss;
    logic fault;
    logic record;
    logic [5:0] opc;
    logic [43:0] next_pa;

    assign hit = lk_hit[lk_pipe];
    assign pte = lk_pte[lk_pipe];
    assign va_bad = lk_va[63:48] != {16{lk_va[47]}};
    assign sp2 = superpage_enables[2] && lk_va[47:46] == `DTM_SP2_VA;
    assign sp1 = superpage_enables[1] && lk_va[47:41] == `DTM_SP1_VA;
    assign sp0 = superpage_enables[0] && lk_va[47:30] == `DTM_SP0_VA;
    assign sp = sp2 || sp1 || sp0;
    assign perm = lk_wr ? pte[`DTM_PTE_WREN_LSB + lk_mode] : pte[`DTM_PTE_RDEN_LSB + lk_mode];
    assign viol = va_bad || (sp && lk_mode != DTM_KERNEL) || (!sp && hit && !perm);
    assign for_f = !va_bad && !sp && hit && !lk_wr && pte[`DTM_PTE_FOR];
    assign wrflt = !va_bad && !sp && hit && lk_wr && pte[`DTM_PTE_WRFLT];
    assign miss = !va_bad && !sp && !hit;
    assign fault = viol || for_f || wrflt || lk_perr;
    assign record = lk_v && (fault || miss) && !(miss && lk_vpte);
    assign opc = lk_hw ? (lk_wr ? `DTM_OPC_HWST : `DTM_OPC_HWLD) : lk_opc;

    // physical address select
    always_comb begin
        next_pa = {pte[`DTM_PTE_PFN_MSB:`DTM_PTE_PFN_LSB], lk_va[12:0]};
        if (sp2) begin
            next_pa = lk_va[43:0];
        end else if (sp1) begin
            next_pa = {{3{lk_va[40]}}, lk_va[40:0]};
        end else if (sp0) begin
            next_pa = {14'h0000, lk_va[29:0]};
        end
    end

    // fault status capture
    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            mem_mgmt_fault_status <= `DTM_FSTAT_RST;
        end else if (record) begin
            mem_mgmt_fault_status[`DTM_FS_PERR] <= lk_perr;
            mem_mgmt_fault_status[`DTM_FS_OPC_LSB +: 6] <= opc;
            mem_mgmt_fault_status[`DTM_FS_WRFLT] <= wrflt;
            mem_mgmt_fault_status[`DTM_FS_FOR] <= for_f;
            mem_mgmt_fault_status[`DTM_FS_VIOL] <= viol;
            mem_mgmt_fault_status[`DTM_FS_WR] <= lk_wr;
        end
    end

    // lookup answer
    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            LKP_DONE_O <= 1'b0;
            LKP_MISS_O <= 1'b0;
            LKP_FAULT_O <= 1'b0;
            LKP_PA_O <= 44'h000_0000_0000;
        end else begin
            LKP_DONE_O <= lk_v;
            LKP_MISS_O <= lk_v && miss;
            LKP_FAULT_O <= lk_v && fault;
            if (lk_v) begin
                LKP_PA_O <= next_pa;
            end
        end
    end
endmodule // dtm_tlb_regs

`default_nettype wire

// >>> common/dtm_cfg.svh
`ifndef DTM_CFG_SVH
`define DTM_CFG_SVH

// register offsets, one aligned word each
`define DTM_PIPE_STRIDE 8'h20
`define DTM_OFS_TAG_LO 8'h00
`define DTM_OFS_TAG_HI 8'h04
`define DTM_OFS_ENT_LO 8'h08
`define DTM_OFS_ENT_HI 8'h0C
`define DTM_OFS_FLS_LO 8'h10
`define DTM_OFS_FLS_HI 8'h14
`define DTM_OFS_PID 8'h18
`define DTM_OFS_ALTMODE 8'h40
`define DTM_OFS_FLUSH_NG 8'h44
`define DTM_OFS_FLUSH_ALL 8'h48
`define DTM_OFS_FSTAT 8'h4C
`define DTM_OFS_MCTL 8'h50

// staged page entry field positions
`define DTM_PTE_FOR 1
`define DTM_PTE_WRFLT 2
`define DTM_PTE_GLB 4
`define DTM_PTE_RDEN_LSB 8
`define DTM_PTE_WREN_LSB 12
`define DTM_PTE_PFN_LSB 32
`define DTM_PTE_PFN_MSB 62

// process id sits in the top byte of its word
`define DTM_PID_LSB 24

// fault status field positions
`define DTM_FS_PERR 10
`define DTM_FS_OPC_LSB 4
`define DTM_FS_WRFLT 3
`define DTM_FS_FOR 2
`define DTM_FS_VIOL 1
`define DTM_FS_WR 0

// control field position and reset values
`define DTM_MCTL_SP_LSB 1
`define DTM_MCTL_RST 3'h0
`define DTM_ALT_RST 2'h0
`define DTM_FSTAT_RST 11'h000

// opcodes reported for privileged hardware accesses
`define DTM_OPC_HWLD 6'h03
`define DTM_OPC_HWST 6'h07

// superpage region selectors
`define DTM_SP2_VA 2'h2
`define DTM_SP1_VA 7'h7E
`define DTM_SP0_VA 18'h3_FFFE

`endif

// >>> common/dtm_pkg.sv
package dtm_pkg;
    typedef enum logic [1:0] {
        DTM_KERNEL = 2'b00,
        DTM_EXEC = 2'b01,
        DTM_SUPER = 2'b10,
        DTM_USER = 2'b11
    } dtm_mode_type;
    typedef logic [34:0] dtm_vpn_type;
    typedef logic [7:0] dtm_asn_type;
    typedef logic [63:0] dtm_pte_type;
endpackage

// >>> src/dtm_xlate_array.sv
`timescale 1ns/1ps
`default_nettype none
`include "dtm_cfg.svh"

module dtm_xlate_array import dtm_pkg::*; #(
    parameter int ENTRIES = 16,
    parameter int IDX_W = $clog2(ENTRIES)
) (
    input wire logic clk_i, // core clock
    input wire logic rst_i, // sync reset
    input wire logic wr_en_i, // fill one slot
    input wire logic [IDX_W-1:0] wr_idx_i, // slot to fill
    input wire dtm_vpn_type wr_vpn_i, // tag page number
    input wire dtm_asn_type wr_asn_i, // owning process
    input wire dtm_pte_type wr_pte_i, // page entry
    input wire logic inv_all_i, // drop every entry
    input wire logic inv_ng_i, // drop non-global entries
    input wire logic inv_one_i, // drop matching page
    input wire dtm_vpn_type inv_vpn_i, // page to drop
    input wire dtm_asn_type inv_asn_i, // process to drop
    input wire logic lk_en_i, // lookup request
    input wire dtm_vpn_type lk_vpn_i, // lookup page
    input wire dtm_asn_type lk_asn_i, // lookup process
    output logic lk_hit_o, // registered hit
    output dtm_pte_type lk_pte_o // registered entry
);
    logic [ENTRIES-1:0] valid;
    logic [ENTRIES-1:0] match;
    dtm_vpn_type vpn [ENTRIES];
    dtm_asn_type process_space_number [ENTRIES];
    dtm_pte_type pte [ENTRIES];
    dtm_pte_type next_pte;

    genvar i;
    generate
        for (i = 0; i < ENTRIES; i++) begin : g_ent
            logic glb;
            assign glb = pte[i][`DTM_PTE_GLB];
            // fill wins over a flush of the same slot
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    valid[i] <= 1'b0;
                    vpn[i] <= '0;
                    process_space_number[i] <= '0;
                    pte[i] <= '0;
                end else if (wr_en_i && wr_idx_i == IDX_W'(i)) begin
                    valid[i] <= 1'b1;
                    vpn[i] <= wr_vpn_i;
                    process_space_number[i] <= wr_asn_i;
                    pte[i] <= wr_pte_i;
                end else if (inv_all_i) begin
                    valid[i] <= 1'b0;
                end else if (inv_ng_i && !glb) begin
                    valid[i] <= 1'b0;
                end else if (inv_one_i && vpn[i] == inv_vpn_i
                             && (process_space_number[i] == inv_asn_i || glb)) begin
                    valid[i] <= 1'b0;
                end
            end
            // associative compare
            assign match[i] = valid[i] && vpn[i] == lk_vpn_i && (glb || process_space_number[i] == lk_asn_i);
        end
    endgenerate

    // pick the matching entry
    always_comb begin
        next_pte = '0;
        for (int k = 0; k < ENTRIES; k++) begin
            if (match[k]) begin
                next_pte = next_pte | pte[k];
            end
        end
    end

    // registered lookup answer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lk_hit_o <= 1'b0;
            lk_pte_o <= '0;
        end else if (lk_en_i) begin
            lk_hit_o <= |match;
            lk_pte_o <= next_pte;
        end
    end
endmodule // dtm_xlate_array

`default_nettype wire

// >>> verif/dtm_tlb_regs_sva.sv
`timescale 1ns/1ps
`default_nettype none

module dtm_tlb_regs_sva (
    input wire logic MCLK_I, // clock
    input wire logic RST_I, // reset
    input wire logic HSEL_I, // select
    input wire logic [31:0] HADDR_I, // address
    input wire logic [1:0] HTRANS_I, // type
    input wire logic HWRITE_I, // write
    input wire logic HREADY_I, // ready
    input wire logic [31:0] HWDATA_I, // write data
    input wire logic LKP_VALID_I, // request
    input wire logic [63:0] LKP_VA_I, // address
    input wire logic [1:0] LKP_MODE_I, // mode
    input wire logic LKP_HWMEM_I, // hw access
    input wire logic LKP_PERR_I, // parity error
    input wire logic LKP_DONE_O, // answer
    input wire logic LKP_MISS_O, // miss
    input wire logic LKP_FAULT_O, // fault
    input wire logic [43:0] LKP_PA_O // physical address
);
    logic ctl_wr; // control write pending
    logic [2:0] ena; // shadow enables
    logic canon, plain, sp2, sp1, sp0; // request classes

    default clocking cb @(posedge MCLK_I);
    endclocking
    default disable iff (RST_I);

    // shadow of the superpage enables
    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            ctl_wr <= 1'b0;
            ena <= 3'h0;
        end else begin
            ctl_wr <= HSEL_I && HTRANS_I[1] && HREADY_I && HWRITE_I && HADDR_I[7:0] == 8'h50;
            if (ctl_wr) begin
                ena <= HWDATA_I[3:1];
            end
        end
    end

    // request classes
    assign canon = LKP_VA_I[63:48] == {16{LKP_VA_I[47]}};
    assign plain = LKP_VALID_I && canon && !LKP_HWMEM_I && !LKP_PERR_I;
    assign sp2 = ena[2] && LKP_VA_I[47:46] == 2'h2;
    assign sp1 = ena[1] && LKP_VA_I[47:41] == 7'h7E;
    assign sp0 = ena[0] && LKP_VA_I[47:30] == 18'h3_FFFE;

    sequence s_kern(sel);
        plain && LKP_MODE_I == 2'h0 && sel;
    endsequence
    sequence s_clean;
        LKP_DONE_O && !LKP_MISS_O && !LKP_FAULT_O;
    endsequence

    a_done_latency: assert property (LKP_VALID_I |-> ##2 LKP_DONE_O)
        else $error("lookup answer late");
    a_done_cause: assert property (LKP_DONE_O |-> $past(LKP_VALID_I, 2))
        else $error("answer without request");
    a_flags_done: assert property ((LKP_MISS_O || LKP_FAULT_O) |-> LKP_DONE_O)
        else $error("flag outside answer");
    a_bad_va: assert property (LKP_VALID_I && !canon |-> ##2 LKP_FAULT_O && !LKP_MISS_O)
        else $error("bad address not a violation");
    a_sp2_map: assert property (s_kern(sp2) |-> ##2 s_clean ##0
        LKP_PA_O[43:13] == $past(LKP_VA_I[43:13], 2)) else $error("region two map wrong");
    a_sp1_map: assert property (s_kern(sp1) |-> ##2 s_clean ##0
        LKP_PA_O[43:13] == {{3{$past(LKP_VA_I[40], 2)}}, $past(LKP_VA_I[40:13], 2)})
        else $error("region one map wrong");
    a_sp0_map: assert property (s_kern(sp0) |-> ##2 s_clean ##0
        LKP_PA_O[43:13] == {14'h0, $past(LKP_VA_I[29:13], 2)}) else $error("region zero map wrong");
    a_sp_user: assert property (plain && LKP_MODE_I != 2'h0 && (sp2 || sp1 || sp0)
        |-> ##2 LKP_DONE_O && LKP_FAULT_O) else $error("superpage outside kernel allowed");
endmodule // dtm_tlb_regs_sva

bind dtm_tlb_regs dtm_tlb_regs_sva u_sva (
    .MCLK_I, .RST_I, .HSEL_I, .HADDR_I, .HTRANS_I, .HWRITE_I, .HREADY_I, .HWDATA_I,
    .LKP_VALID_I, .LKP_VA_I, .LKP_MODE_I, .LKP_HWMEM_I, .LKP_PERR_I,
    .LKP_DONE_O, .LKP_MISS_O, .LKP_FAULT_O, .LKP_PA_O
);
`default_nettype wire

// >>> verif/dtm_core_model.sv
`timescale 1ns/1ps
`default_nettype none

module dtm_core_model (
    input wire logic clk_i, // core clock
    output logic valid_o, // request pulse
    output logic pipe_o, // memory pipe
    output logic [63:0] va_o, // virtual address
    output logic write_o, // store
    output logic [5:0] opcode_o, // opcode
    output logic hwmem_o, // hw access
    output logic vpte_o, // page entry load
    output logic perr_o, // parity error
    output logic [1:0] mode_o // current mode
);
    // idle lines at time zero
    initial begin
        {valid_o, pipe_o, va_o, write_o, opcode_o, hwmem_o, vpte_o, perr_o, mode_o} = '0;
    end

    // one request for one cycle, then address and opcode lines garbled
    task automatic issue(input logic p, input logic [63:0] va, input logic [1:0] md,
            input logic [3:0] f);
        @(posedge clk_i);
        valid_o <= 1'b1;
        pipe_o <= p;
        va_o <= va;
        mode_o <= md;
        {write_o, hwmem_o, vpte_o, perr_o} <= f;
        opcode_o <= 6'h2A;
        @(posedge clk_i);
        valid_o <= 1'b0;
        va_o <= ~va;
        opcode_o <= 6'h15;
    endtask
endmodule // dtm_core_model
`default_nettype wire

// >>> verif/dtm_tlb_regs_test.sv
`timescale 1ns/1ps
`default_nettype none

module dtm_tlb_regs_test import dtm_pkg::*;;
    typedef struct packed {
        logic [63:0] va;
        logic [1:0] md;
        logic [3:0] f;
        logic mi;
        logic fa;
        logic [43:0] pa;
        logic [10:0] st;
    } dtm_row_type;

    localparam logic [63:0] va_a = 64'h0000_0000_1000_0000, va_g = 64'h0000_0000_4000_0000;
    localparam logic [63:0] va_s = 64'hFFFF_FFFF_8000_4000;
    localparam logic [43:0] pa_a = 44'h000_000A_A000;
    logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic hrdy, hresp, l_v, l_p, l_w, l_hw, l_vp, l_pe, done, miss, fault;
    logic [63:0] l_va;
    logic [5:0] l_op;
    logic [1:0] l_md;
    logic [43:0] pa;
    int num_errors = 0, cmp_count = 0;
    // va, mode, {write,hw,vpte,perr}, miss, fault, pa, status
    dtm_row_type rows [10] = '{
        '{64'hFFFF_8123_4567_E000, 2'h0, 4'h0, 1'b0, 1'b0, 44'h123_4567_E000, 11'h2A0},
        '{64'hFFFF_FD00_0000_2000, 2'h0, 4'h0, 1'b0, 1'b0, 44'hF00_0000_2000, 11'h2A0},
        '{va_s, 2'h0, 4'h0, 1'b0, 1'b0, 44'h000_0000_4000, 11'h2A0},
        '{va_s, 2'h3, 4'h0, 1'b0, 1'b1, 44'h0, 11'h2A2},
        '{64'h0001_0000_0000_0000, 2'h0, 4'h8, 1'b0, 1'b1, 44'h0, 11'h2A3},
        '{64'h0000_0000_7000_0000, 2'h0, 4'h8, 1'b1, 1'b0, 44'h0, 11'h2A1},
        '{64'h0000_0000_7000_0000, 2'h0, 4'h2, 1'b1, 1'b0, 44'h0, 11'h2A1},
        '{va_s, 2'h0, 4'h1, 1'b0, 1'b1, 44'h0, 11'h6A0},
        '{va_a, 2'h3, 4'h0, 1'b1, 1'b0, 44'h0, 11'h2A0},
        '{va_a ^ 64'h1, 2'h3, 4'h0, 1'b0, 1'b0, pa_a, 11'h2A0}};

    always #4 clk = ~clk;

    dtm_core_model core (.clk_i(clk), .valid_o(l_v), .pipe_o(l_p), .va_o(l_va), .write_o(l_w),
        .opcode_o(l_op), .hwmem_o(l_hw), .vpte_o(l_vp), .perr_o(l_pe), .mode_o(l_md));
    dtm_tlb_regs dut (.MCLK_I(clk), .RST_I(rst), .HSEL_I(hsel), .HADDR_I(haddr),
        .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HREADY_I(hrdy),
        .HWDATA_I(hwdata), .HREADYOUT_O(hrdy), .HRESP_O(hresp), .HRDATA_O(hrdata),
        .LKP_VALID_I(l_v), .LKP_PIPE_I(l_p), .LKP_VA_I(l_va), .LKP_WRITE_I(l_w),
        .LKP_OPCODE_I(l_op), .LKP_HWMEM_I(l_hw), .LKP_VPTE_I(l_vp), .LKP_PERR_I(l_pe),
        .LKP_MODE_I(l_md), .LKP_DONE_O(done), .LKP_MISS_O(miss), .LKP_FAULT_O(fault),
        .LKP_PA_O(pa));

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one single transfer: address phase, then data phase
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        @(posedge clk);
        while (hrdy !== 1'b1) @(posedge clk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hrdy !== 1'b1) @(posedge clk);
        q = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(64'({hresp, q}), 64'(e));
    endtask

    // stage tag, then entry words; high word commits
    task automatic fill(input logic [31:0] t, input logic [31:0] lo, input logic [31:0] hi);
        wr(8'h00, t);
        wr(8'h08, lo);
        wr(8'h0C, hi);
    endtask

    task automatic lk(input logic [63:0] va, input logic [1:0] md, input logic [3:0] f,
            input logic mi, input logic fa, input logic [43:0] e);
        int n = 0;
        core.issue(va[0], va & ~64'h1, md, f);
        while (done !== 1'b1 && n < 8) begin
            @(posedge clk);
            n++;
        end
        chk(64'({done, miss, fault}), 64'({1'b1, mi, fa}));
        if (!mi && !fa) begin
            chk(64'(pa), 64'(e));
        end
    endtask

    task automatic finish_test();
        $display("compares %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(8'h4C, 32'h0);
        wr(8'h80, 32'hFFFF_FFFF);
        rd(8'h80, 32'h0);
        rd(8'h50, 32'h0);
        lk(va_s, 2'h0, 4'h0, 1'b1, 1'b0, 44'h0);
        wr(8'h50, 32'h0000_000E);
        wr(8'h18, 32'h5A00_0000);
        wr(8'h38, 32'h5A00_0000);
        wr(8'h20, 32'h1000_0000);
        wr(8'h28, 32'h0000_FF00);
        wr(8'h2C, 32'h0000_0055);
        foreach (rows[i]) begin
            lk(rows[i].va, rows[i].md, rows[i].f, rows[i].mi, rows[i].fa, rows[i].pa);
            rd(8'h4C, 32'(rows[i].st));
        end
        fill(32'h3000_0000, 32'h0000_FF06, 32'h0000_0066);
        lk(64'h3000_0000, 2'h0, 4'h0, 1'b0, 1'b1, 44'h0);
        rd(8'h4C, 32'h2A4);
        lk(64'h3000_0000, 2'h0, 4'h8, 1'b0, 1'b1, 44'h0);
        rd(8'h4C, 32'h2A9);
        wr(8'h00, 32'h2000_0000);
        lk(64'h2000_0000, 2'h0, 4'h0, 1'b1, 1'b0, 44'h0);
        fill(32'h4000_0000, 32'h0000_FF10, 32'h0000_0077);
        wr(8'h44, 32'h0);
        lk(va_a ^ 64'h1, 2'h0, 4'h0, 1'b1, 1'b0, 44'h0);
        lk(va_g, 2'h0, 4'h0, 1'b0, 1'b0, 44'h000_000E_E000);
        wr(8'h18, 32'h3300_0000);
        wr(8'h10, 32'h4000_0000);
        wr(8'h14, 32'h0);
        lk(va_g, 2'h0, 4'h0, 1'b1, 1'b0, 44'h0);
        fill(32'h1000_0000, 32'h0000_FF00, 32'h0000_0055);
        for (int k = 0; k < 2; k++) begin
            wr(8'h18, k == 0 ? 32'h5A00_0000 : 32'h3300_0000);
            wr(8'h10, 32'h1000_0000);
            wr(8'h14, 32'h0);
            wr(8'h18, 32'h3300_0000);
            lk(va_a, 2'h0, 4'h0, k == 1, 1'b0, pa_a);
        end
        for (int m = 0; m < 4; m++) begin
            wr(8'h40, 32'(m));
            lk(va_s, DTM_KERNEL, 4'hC, 1'b0, m != 0, 44'h000_0000_4000);
            rd(8'h4C, m != 0 ? 32'h73 : 32'h2A0);
        end
        lk(va_s, DTM_KERNEL, 4'h4, 1'b0, 1'b1, 44'h0);
        rd(8'h4C, 32'h32);
        fill(32'h1000_0000, 32'h0000_FF00, 32'h0000_0055);
        wr(8'h48, 32'h0);
        lk(va_a, 2'h0, 4'h0, 1'b1, 1'b0, 44'h0);
        for (int k = 0; k < 17; k++) begin
            fill(32'(k) << 13, 32'h0000_FF00, 32'(k));
        end
        lk(64'h0, 2'h0, 4'h0, 1'b1, 1'b0, 44'h0);
        lk(64'h2000, 2'h0, 4'h0, 1'b0, 1'b0, 44'h000_0000_2000);
        finish_test();
    end

    // hang guard
    initial begin
        #200_000;
        num_errors++;
        finish_test();
    end
endmodule // dtm_tlb_regs_test
`default_nettype wire
